/* File: inc/bcs_cfg.svh */
// Timing constants and counter widths of the buck switch controller.
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH
`define BCS_CLK_MHZ 200
`define BCS_LEB_NS 300
`define BCS_LEB_CYC ((`BCS_LEB_NS * `BCS_CLK_MHZ + 999) / 1000)
`define BCS_TON_MAX_NS 15000
`define BCS_TON_MAX_CYC ((`BCS_TON_MAX_NS * `BCS_CLK_MHZ) / 1000)
`define BCS_TOFF_MAX_NS 50000
`define BCS_TOFF_MAX_CYC ((`BCS_TOFF_MAX_NS * `BCS_CLK_MHZ) / 1000)
`define BCS_SC_DET_US 20000
`define BCS_SC_DET_CYC ((`BCS_SC_DET_US * `BCS_CLK_MHZ))
`define BCS_CNT_W 24
`define BCS_SC_W 32
`endif

/* File: inc/bcs_pkg.sv */
// Types shared by the buck switch controller.
package bcs_pkg;
  typedef enum logic [2:0] {
    ST_OFF_IDLE = 3'b000,
    ST_ON_BLANK = 3'b001,
    ST_ON_ARMED = 3'b010,
    ST_FREEWHEEL = 3'b011,
    ST_HALT = 3'b100,
    ST_LATCHED = 3'b101
  } bcs_state_type;
endpackage

/* File: rtl/bcs_ctrl.sv */
// Switching-cycle sequencer of a boundary-conduction buck LED driver.
`include "bcs_cfg.svh"

module bcs_ctrl #(
  parameter int unsigned LEB_CYC = `BCS_LEB_CYC,
  parameter int unsigned TON_MAX_CYC = `BCS_TON_MAX_CYC,
  parameter int unsigned TOFF_MAX_CYC = `BCS_TOFF_MAX_CYC,
  parameter int unsigned SC_DET_CYC = `BCS_SC_DET_CYC
) (
  input wire logic mclk_i, // 200 MHz system clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic peak_i, // Current-sense peak comparator.
  input wire logic valley_i, // Drain valley comparator.
  input wire logic ring_freq_ok_i, // Ringing frequency in range.
  input wire logic swing_ok_i, // Drain swing in range.
  input wire logic supply_above_stop_i, // Supply above supply_stop_level.
  input wire logic supply_above_reset_i, // Supply above supply_reset_level.
  input wire logic ic_overtemp_i, // Internal overtemperature.
  input wire logic led_overtemp_i, // LED overtemperature.
  input wire logic on_time_limit_input_i, // On-time modulation threshold reached.
  input wire logic on_time_input_bad_i, // On-time input open or shorted.
  output logic gate_o, // Power switch gate command.
  output logic hv_startup_o, // Request power from high-voltage start-up source.
  output logic output_short_fault_o // Latched output short protection.
);
  localparam int SW = 10;

  typedef struct packed {
    bcs_pkg::bcs_state_type state;
    logic gate;
    logic hv;
    logic [`BCS_CNT_W-1:0] cnt;
    logic [`BCS_SC_W-1:0] sc_cnt;
    logic sc_run;
  } bcs_st_type;

  bcs_st_type st_r;
  bcs_st_type st_nxt;
  logic [SW-1:0] raw;
  logic [SW-1:0] s;
  logic peak_s;
  logic valley_s;
  logic valley_ok;
  logic fault;
  logic stop_s;
  logic rst_lvl_s;
  logic ton_cap;

  assign raw = {on_time_input_bad_i, peak_i, valley_i, ring_freq_ok_i, swing_ok_i,
                supply_above_stop_i, supply_above_reset_i, ic_overtemp_i, led_overtemp_i,
                on_time_limit_input_i};

  bcs_sync #(.W(SW)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(raw),
    .sync_o(s)
  );

  assign peak_s = s[8];
  assign valley_s = s[7];
  assign valley_ok = valley_s && s[6] && s[5];
  assign stop_s = !s[4];
  assign rst_lvl_s = !s[3];
  assign fault = s[2] || s[1];
  // A bad on-time input uses only the internal maximum; otherwise the input may end it earlier.
  assign ton_cap = (st_r.cnt >= `BCS_CNT_W'(TON_MAX_CYC - 1))
                   || (!s[9] && s[0]);

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = st_r.cnt + `BCS_CNT_W'(1);
    if (st_r.sc_run) begin
      st_nxt.sc_cnt = st_r.sc_cnt + `BCS_SC_W'(1);
    end
    unique case (st_r.state)
      bcs_pkg::ST_OFF_IDLE: begin
        st_nxt.gate = 1'b0;
        st_nxt.hv = stop_s;
        if (!stop_s && !fault) begin
          st_nxt.state = bcs_pkg::ST_ON_BLANK;
          st_nxt.gate = 1'b1;
          st_nxt.cnt = '0;
        end
      end
      bcs_pkg::ST_ON_BLANK: begin
        if (st_r.cnt >= `BCS_CNT_W'(LEB_CYC - 1)) begin
          st_nxt.state = bcs_pkg::ST_ON_ARMED;
        end
        if (ton_cap) begin
          st_nxt.state = bcs_pkg::ST_FREEWHEEL;
          st_nxt.gate = 1'b0;
          st_nxt.cnt = '0;
          st_nxt.sc_run = 1'b0;
          st_nxt.sc_cnt = '0;
        end
      end
      bcs_pkg::ST_ON_ARMED: begin
        if (peak_s) begin
          st_nxt.state = bcs_pkg::ST_FREEWHEEL;
          st_nxt.gate = 1'b0;
          st_nxt.cnt = '0;
        end else if (ton_cap) begin
          st_nxt.state = bcs_pkg::ST_FREEWHEEL;
          st_nxt.gate = 1'b0;
          st_nxt.cnt = '0;
          st_nxt.sc_run = 1'b0;
          st_nxt.sc_cnt = '0;
        end
      end
      bcs_pkg::ST_FREEWHEEL: begin
        if (valley_ok) begin
          st_nxt.state = bcs_pkg::ST_ON_BLANK;
          st_nxt.gate = 1'b1;
          st_nxt.cnt = '0;
          st_nxt.sc_run = 1'b0;
          st_nxt.sc_cnt = '0;
        end else if (st_r.cnt >= `BCS_CNT_W'(TOFF_MAX_CYC - 1)) begin
          st_nxt.state = bcs_pkg::ST_ON_BLANK;
          st_nxt.gate = 1'b1;
          st_nxt.cnt = '0;
          st_nxt.sc_run = 1'b1;
        end
      end
      bcs_pkg::ST_HALT: begin
        st_nxt.gate = 1'b0;
        if (stop_s) begin
          st_nxt.state = bcs_pkg::ST_OFF_IDLE;
          st_nxt.hv = 1'b1;
        end
      end
      bcs_pkg::ST_LATCHED: begin
        st_nxt.gate = 1'b0;
        st_nxt.sc_run = 1'b0;
        st_nxt.hv = stop_s;
        if (rst_lvl_s) begin
          st_nxt.state = bcs_pkg::ST_OFF_IDLE;
          st_nxt.sc_cnt = '0;
        end
      end
      default: begin
        st_nxt.state = bcs_pkg::ST_OFF_IDLE;
        st_nxt.gate = 1'b0;
      end
    endcase
    if (st_r.state != bcs_pkg::ST_LATCHED) begin
      if (st_r.sc_run && st_r.sc_cnt >= `BCS_SC_W'(SC_DET_CYC - 1)) begin
        st_nxt.state = bcs_pkg::ST_LATCHED;
        st_nxt.gate = 1'b0;
        st_nxt.sc_run = 1'b0;
      end else if (stop_s) begin
        st_nxt.state = bcs_pkg::ST_OFF_IDLE;
        st_nxt.gate = 1'b0;
        st_nxt.hv = 1'b1;
        st_nxt.sc_run = 1'b0;
        st_nxt.sc_cnt = '0;
      end else if (fault && st_r.state != bcs_pkg::ST_OFF_IDLE) begin
        st_nxt.state = bcs_pkg::ST_HALT;
        st_nxt.gate = 1'b0;
        st_nxt.hv = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{state: bcs_pkg::ST_OFF_IDLE, gate: 1'b0, hv: 1'b1, cnt: '0,
                sc_cnt: '0, sc_run: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gate_o = st_r.gate;
  assign hv_startup_o = st_r.hv;
  assign output_short_fault_o = (st_r.state == bcs_pkg::ST_LATCHED);

  ////////////////////////////////////////////////////////////////////////////////

  gate_off_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    stop_s && st_r.state != bcs_pkg::ST_LATCHED |=> !gate_o)
    else $error("Gate stayed on below stop level.");

  blank_ignores_peak_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == bcs_pkg::ST_ON_BLANK && !ton_cap |=> st_r.state != bcs_pkg::ST_FREEWHEEL)
    else $error("Peak acted during blanking.");

  blank_arms_late_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == bcs_pkg::ST_ON_BLANK && st_r.cnt < `BCS_CNT_W'(LEB_CYC - 1)
    |=> st_r.state != bcs_pkg::ST_ON_ARMED)
    else $error("Peak detection armed too early.");

  peak_turns_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == bcs_pkg::ST_ON_ARMED && peak_s && !stop_s && !fault |=> !gate_o)
    else $error("Peak did not turn switch off.");

  valley_starts_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == bcs_pkg::ST_FREEWHEEL && valley_ok && !stop_s && !fault
    && !st_r.sc_run |=> gate_o)
    else $error("Valid valley did not start a cycle.");

  bad_valley_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == bcs_pkg::ST_FREEWHEEL && valley_s && !(s[6] && s[5])
    && st_r.cnt < `BCS_CNT_W'(TOFF_MAX_CYC - 1) |=> !gate_o)
    else $error("Unqualified valley accepted.");

  toff_limit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == bcs_pkg::ST_FREEWHEEL |-> st_r.cnt < `BCS_CNT_W'(TOFF_MAX_CYC))
    else $error("Off-time passed its limit.");

  ton_limit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    gate_o |-> st_r.cnt < `BCS_CNT_W'(TON_MAX_CYC))
    else $error("On-time passed its limit.");

  no_start_fault_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == bcs_pkg::ST_OFF_IDLE && fault |=> !gate_o)
    else $error("Switching started with a fault.");

  latch_holds_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == bcs_pkg::ST_LATCHED && !rst_lvl_s |=> st_r.state == bcs_pkg::ST_LATCHED)
    else $error("Latch cleared without supply reset.");
endmodule

/* File: rtl/bcs_sync.sv */
// Two-stage synchroniser for a group of asynchronous comparator flags.
module bcs_sync #(
  parameter int W = 8
) (
  input wire logic mclk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [W-1:0] async_i, // Raw comparator flags.
  output logic [W-1:0] sync_o // Synchronised flags.
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } bcs_sync_st_type;
  bcs_sync_st_type st_r;
  bcs_sync_st_type st_nxt;

  always_comb begin
    st_nxt.meta = async_i;
    st_nxt.stab = st_r.meta;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.stab;
endmodule

/* File: tb/bcs_stage_model.sv */
// Behavioural model of the buck stage comparators seen by the controller.
module bcs_stage_model (
  input wire logic mclk_i, // System clock.
  input wire logic gate_i, // Switch gate command.
  input wire logic [15:0] peak_dly_i, // On cycles to peak, zero for never.
  input wire logic [15:0] valley_dly_i, // Off cycles to valley, zero for never.
  output logic peak_o, // Peak current reached.
  output logic valley_o // Drain at its lowest point.
);
  timeunit 1ns;
  timeprecision 1ps;
  int on_n = 0;
  int off_n = 0;
  always @(posedge mclk_i) begin
    on_n <= gate_i ? on_n + 1 : 0;
    off_n <= gate_i ? 0 : off_n + 1;
  end
  // Current builds only while the switch conducts.
  assign peak_o = gate_i && peak_dly_i != 16'h0000 && on_n >= int'(peak_dly_i);
  // The drain rings only once the freewheel stroke is over.
  assign valley_o = !gate_i && valley_dly_i != 16'h0000 && off_n >= int'(valley_dly_i);
endmodule

/* File: tb/tb_bcs_ctrl.sv */
// Self-checking bench of the buck switch controller.
module tb_bcs_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LEB = 4;
  localparam int TON = 40;
  localparam int TOFF = 60;
  localparam int SCD = 500;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ring = 1'b1, swing = 1'b1, stop = 1'b1, rlev = 1'b1;
  logic ic_ot = 1'b0, led_ot = 1'b0, lim = 1'b0, bad = 1'b1;
  logic [15:0] pk = 16'h0014, vl = 16'h000A;
  logic peak, valley, gate, hv, short_f;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  always #2.5 mclk_i = ~mclk_i;
  bcs_stage_model u_bcs_stage_model (.mclk_i(mclk_i), .gate_i(gate), .peak_dly_i(pk),
    .valley_dly_i(vl), .peak_o(peak), .valley_o(valley));
  bcs_ctrl #(.LEB_CYC(LEB), .TON_MAX_CYC(TON), .TOFF_MAX_CYC(TOFF), .SC_DET_CYC(SCD)) u_bcs_ctrl (
    .mclk_i(mclk_i), .rst_i(rst_i), .peak_i(peak), .valley_i(valley), .ring_freq_ok_i(ring),
    .swing_ok_i(swing), .supply_above_stop_i(stop), .supply_above_reset_i(rlev),
    .ic_overtemp_i(ic_ot), .led_overtemp_i(led_ot), .on_time_limit_input_i(lim),
    .on_time_input_bad_i(bad), .gate_o(gate), .hv_startup_o(hv),
    .output_short_fault_o(short_f));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic go(input int c);
    repeat (c) @(posedge mclk_i);
  endtask
  // Returns the cycles waited for the gate to reach a level.
  task automatic wt(input logic lvl, output int w);
    w = 0;
    while (gate !== lvl && w < 4000) begin
      @(posedge mclk_i);
      w++;
    end
  endtask
  // Measures one whole phase of the gate at the given level.
  task automatic span(input logic lvl, output int c);
    wt(!lvl, c);
    wt(lvl, c);
    c = 0;
    while (gate === lvl && c < 4000) begin
      @(posedge mclk_i);
      c++;
    end
  endtask
  task automatic low(input int c);
    int b;
    b = 0;
    repeat (c) begin
      @(posedge mclk_i);
      if (gate !== 1'b0) b++;
    end
    chk_rng(b, 0, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cycle();
    wt(1'b1, n);
    chk_rng(n, 2, 8);
    pk <= 16'h0001;
    span(1'b1, n);
    chk_rng(n, LEB + 1, LEB + 3);
    pk <= 16'h0014;
    span(1'b1, n);
    chk_rng(n, 20, 26);
    span(1'b0, n);
    chk_rng(n, 10, 16);
  endtask
  task automatic t_unqual();
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i);
      ring <= i[0];
      swing <= !i[0];
      span(1'b0, n);
      span(1'b0, n);
      chk_rng(n, TOFF - 1, TOFF + 6);
    end
    ring <= 1'b1;
    swing <= 1'b1;
  endtask
  task automatic t_cap();
    pk <= 16'h0000;
    lim <= 1'b1;
    span(1'b1, n);
    span(1'b1, n);
    chk_rng(n, TON - 1, TON + 5);
    bad <= 1'b0;
    lim <= 1'b1;
    span(1'b1, n);
    span(1'b1, n);
    chk_rng(n, 1, TON - 6);
    bad <= 1'b1;
    lim <= 1'b0;
    pk <= 16'h0014;
  endtask
  task automatic t_halt(input int k);
    @(posedge mclk_i);
    if (k == 0) ic_ot <= 1'b1;
    else led_ot <= 1'b1;
    go(40);
    low(200);
    stop <= 1'b0;
    go(10);
    chk_bit(hv, 1'b1);
    low(50);
    stop <= 1'b1;
    low(50);
    ic_ot <= 1'b0;
    led_ot <= 1'b0;
    wt(1'b1, n);
    chk_rng(n, 2, 30);
  endtask
  task automatic t_short();
    vl <= 16'h0000;
    n = 0;
    while (short_f !== 1'b1 && n < 2000) begin
      @(posedge mclk_i);
      n++;
    end
    chk_rng(n, SCD, SCD + 300);
    low(100);
    stop <= 1'b0;
    go(10);
    chk_bit(short_f, 1'b1);
    rlev <= 1'b0;
    vl <= 16'h000A;
    go(10);
    chk_bit(short_f, 1'b0);
    rlev <= 1'b1;
    stop <= 1'b1;
    wt(1'b1, n);
    chk_rng(n, 2, 30);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d, mismatched %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    go(6);
    rst_i <= 1'b0;
    t_cycle();
    t_unqual();
    t_cap();
    t_halt(0);
    t_halt(1);
    t_short();
    close_out();
  end
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule
